// ==== src/mgmt_pkg.sv ====
// Constants and carrier types for the module management control block
package mgmt_pkg;

  // ==========================================================================
  // Clock rate and documented response times
  // ==========================================================================
  localparam int unsigned REF_MHZ     = 50;
  localparam int unsigned T_INIT_MS   = 2000;
  localparam int unsigned T_RST_US    = 2;
  localparam int unsigned T_LP_US     = 100;
  localparam int unsigned T_INTON_MS  = 200;
  localparam int unsigned T_INTOFF_US = 500;
  localparam int unsigned T_LOS_MS    = 100;
  localparam int unsigned T_MASK_MS   = 100;
  localparam int unsigned T_SEL_US    = 100;
  localparam int unsigned T_PDON_MS   = 100;
  localparam int unsigned T_PDOFF_MS  = 300;

  // ==========================================================================
  // Derived cycle counts
  // ==========================================================================
  localparam int unsigned INIT_CYC   = T_INIT_MS * 1000 * REF_MHZ;
  localparam int unsigned RST_MIN_CYC = T_RST_US * REF_MHZ;
  localparam int unsigned LP_CYC     = T_LP_US * REF_MHZ;
  localparam int unsigned SEL_CYC    = T_SEL_US * REF_MHZ;
  localparam int unsigned INTOFF_CYC = T_INTOFF_US * REF_MHZ;
  localparam int unsigned WAKE_CYC   = T_PDOFF_MS * 1000 * REF_MHZ;
  localparam int unsigned CNT_W      = 32;

  // ==========================================================================
  // Flag layout
  // ==========================================================================
  localparam int unsigned NFLAG     = 4;
  localparam int unsigned NCOND     = 3;
  localparam int unsigned FLAG_RDY  = 0;
  localparam int unsigned FLAG_LOS  = 1;
  localparam int unsigned FLAG_TXF  = 2;
  localparam int unsigned FLAG_ALM  = 3;

  typedef struct packed {
    logic             pdown;
    logic [NFLAG-1:0] mask;
  } wr_word_t;

  typedef struct packed {
    logic [NFLAG-1:0] flags;
    logic             not_ready;
  } status_t;

  localparam wr_word_t WR_RST = '{pdown: 1'b0, mask: 4'h0};

endpackage : mgmt_pkg

// ==== src/mgmt_ctrl.sv ====
// Management control and status logic of a pluggable transceiver module
`timescale 1ns/100ps

// Notes on behaviour
// - Fully functional within 2000 ms of power-on
// - Reset pin low over 2 us resets
// - Serial bus answers within 2000 ms
// - Not-ready clears, interrupt asserts within 2000 ms
// - Functional within 2000 ms after reset release
// - Low-power request lowers power within 100 us
// - Interrupt asserts within 200 ms of cause
// - Clear-on-read releases interrupt within 500 us
// - Loss-of-signal sets bit, interrupts within 100 ms
// - Flag condition sets bit, interrupts within 200 ms
// - Setting mask inhibits interrupt within 100 ms
// - Clearing mask resumes interrupt within 100 ms
// - Select asserted: answer bus within 100 us
// - Select released: stop answering within 100 us
// - Power-down bit set lowers power within 100 ms
// - Power-down bit cleared: functional within 300 ms
// - Functional means interrupt from not-ready clear
// - Write timing counts from edge after stop
// - Transmit disable high or open stops laser
module mgmt_ctrl
  import mgmt_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC,
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
)(
  // Clocks and reset
  input  wire logic             REF_CLK,
  input  wire logic             RST_N,
  input  wire logic             SERIAL_CLK,
  // Host control pins and internal conditions
  input  wire logic             MODULE_RESET_N,
  input  wire logic             MODULE_SELECT_N,
  input  wire logic             LOW_POWER_REQUEST,
  input  wire logic             TRANSMIT_DISABLE_IN,
  input  wire logic [NCOND-1:0] FLAG_COND,
  // Module outputs
  output logic                  INTERRUPT_OUT_N,
  output logic                  MODULE_PRESENT_N,
  output logic                  LOW_POWER,
  output logic                  LASER_EN,
  output logic                  BUS_EN,
  // Serial engine side, on SERIAL_CLK
  input  wire logic             RD_DONE,
  input  wire logic [NFLAG-1:0] RD_SEL,
  input  wire logic             WR_DONE,
  input  wire wr_word_t         WR_WORD,
  output status_t               STATUS
);

  typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_PDOWN, ST_WAKE} state_t;

  // ==========================================================================
  // Link domain: strobes from the serial engine
  // ==========================================================================
  logic             rd_tgl_ff;
  logic             wr_tgl_ff;
  logic [NFLAG-1:0] rd_sel_ff;
  wr_word_t         wr_word_ff;
  status_t          st_meta_ff;
  status_t          st_sync_ff;
  // Reference-domain status word, carried across per bit
  status_t          status_ref;

  // Engine pulses these on the falling edge after the stop bit
  always_ff @(posedge SERIAL_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rd_tgl_ff <= 1'b0;
      rd_sel_ff <= '0;
    end
    else if (RD_DONE)
    begin
      rd_tgl_ff <= ~rd_tgl_ff;
      rd_sel_ff <= RD_SEL;
    end
  end

  always_ff @(posedge SERIAL_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_tgl_ff  <= 1'b0;
      wr_word_ff <= WR_RST;
    end
    else if (WR_DONE)
    begin
      wr_tgl_ff  <= ~wr_tgl_ff;
      wr_word_ff <= WR_WORD;
    end
  end

  // Status bits are independent levels, so a per-bit sync is enough
  always_ff @(posedge SERIAL_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_meta_ff <= '0;
      st_sync_ff <= '0;
    end
    else
    begin
      st_meta_ff <= status_ref;
      st_sync_ff <= st_meta_ff;
    end
  end

  assign STATUS = st_sync_ff;

  // ==========================================================================
  // Reference domain: synchronisers
  // ==========================================================================
  localparam int unsigned NSYNC = NCOND + 6;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_meta_ff;
  logic [NSYNC-1:0] pin_sync_ff;
  logic [NSYNC-1:0] pin_last_ff;

  // Toggles travel with the pins; data words settle long before
  assign pin_raw = {FLAG_COND, rd_tgl_ff, wr_tgl_ff, TRANSMIT_DISABLE_IN,
                    LOW_POWER_REQUEST, MODULE_SELECT_N, MODULE_RESET_N};

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin_meta_ff <= 9'h03;
      pin_sync_ff <= 9'h03;
      pin_last_ff <= 9'h03;
    end
    else
    begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
      pin_last_ff <= pin_sync_ff;
    end
  end

  logic             mrst_n_s;
  logic             sel_n_s;
  logic             lp_s;
  logic             transmit_disable_in_s;
  logic             wr_pulse;
  logic             rd_pulse;
  logic [NCOND-1:0] cond_s;
  logic [NCOND-1:0] cond_rise;

  assign mrst_n_s  = pin_sync_ff[0];
  assign sel_n_s   = pin_sync_ff[1];
  assign lp_s      = pin_sync_ff[2];
  assign transmit_disable_in_s    = pin_sync_ff[3];
  assign wr_pulse  = pin_sync_ff[4] ^ pin_last_ff[4];
  assign rd_pulse  = pin_sync_ff[5] ^ pin_last_ff[5];
  assign cond_s    = pin_sync_ff[NSYNC-1:6];
  assign cond_rise = cond_s & ~pin_last_ff[NSYNC-1:6];

  // ==========================================================================
  // Module reset pulse filter
  // ==========================================================================
  logic [7:0] rst_low_cnt_ff;
  logic       soft_rst;

  assign soft_rst = (rst_low_cnt_ff == 8'(RST_MIN_CYC - 1)) && !mrst_n_s;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_low_cnt_ff <= 8'h00;
    else if (mrst_n_s)
      rst_low_cnt_ff <= 8'h00;
    else if (rst_low_cnt_ff != 8'(RST_MIN_CYC - 1))
      rst_low_cnt_ff <= rst_low_cnt_ff + 8'h01;
  end

  // Held in reset while the pin stays low past the filter
  logic rst_hold_ff;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_hold_ff <= 1'b0;
    else if (soft_rst)
      rst_hold_ff <= 1'b1;
    else if (mrst_n_s)
      rst_hold_ff <= 1'b0;
  end

  // ==========================================================================
  // Control registers written over the serial bus
  // ==========================================================================
  logic [NFLAG-1:0] mask_ff;
  logic             pdown_ff;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mask_ff  <= WR_RST.mask;
      pdown_ff <= WR_RST.pdown;
    end
    else if (soft_rst)
    begin
      mask_ff  <= WR_RST.mask;
      pdown_ff <= WR_RST.pdown;
    end
    else if (wr_pulse)
    begin
      mask_ff  <= wr_word_ff.mask;
      pdown_ff <= wr_word_ff.pdown;
    end
  end

  // ==========================================================================
  // Initialisation and power state machine
  // ==========================================================================
  state_t           state_ff;
  state_t           nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic             cnt_done;
  logic             not_ready_ff;

  assign cnt_done = (state_ff == ST_INIT) ? (cnt_ff >= CNT_W'(INIT_CYCLES - 1))
                                          : (cnt_ff >= CNT_W'(WAKE_CYCLES - 1));

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_INIT:  if (cnt_done && !rst_hold_ff) nxt_state = ST_RUN;
      ST_RUN:   if (pdown_ff) nxt_state = ST_PDOWN;
      ST_PDOWN: if (!pdown_ff) nxt_state = ST_WAKE;
      ST_WAKE:
        if (pdown_ff)
          nxt_state = ST_PDOWN;
        else if (cnt_done)
          nxt_state = ST_RUN;
    endcase
    if (soft_rst)
      nxt_state = ST_INIT;
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      state_ff <= ST_INIT;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      cnt_ff <= '0;
    else if (nxt_state != state_ff || rst_hold_ff)
      cnt_ff <= '0;
    else if (!cnt_done)
      cnt_ff <= cnt_ff + CNT_W'(1);
  end

  // Not-ready stays set until the first pass out of init
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      not_ready_ff <= 1'b1;
    else if (soft_rst)
      not_ready_ff <= 1'b1;
    else if (state_ff == ST_INIT && nxt_state == ST_RUN)
      not_ready_ff <= 1'b0;
  end

  // ==========================================================================
  // Sticky flags, clear on read
  // ==========================================================================
  logic [NFLAG-1:0] flag_ff;
  logic [NFLAG-1:0] flag_set;
  logic [NFLAG-1:0] rd_clr;
  logic             rdy_event;

  assign rdy_event = not_ready_ff && state_ff == ST_INIT && nxt_state == ST_RUN;
  assign flag_set  = {cond_rise, rdy_event};
  assign rd_clr    = rd_pulse ? rd_sel_ff : '0;

  generate
    for (genvar i = 0; i < NFLAG; i++)
    begin : g_flag
      // A set in the clearing cycle wins, so no event is lost
      always_ff @(posedge REF_CLK or negedge RST_N)
      begin
        if (!RST_N)
          flag_ff[i] <= 1'b0;
        else if (soft_rst)
          flag_ff[i] <= 1'b0;
        else if (flag_set[i])
          flag_ff[i] <= 1'b1;
        else if (rd_clr[i])
          flag_ff[i] <= 1'b0;
      end
    end
  endgenerate

  assign status_ref = '{flags: flag_ff, not_ready: not_ready_ff};

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic pend;

  assign pend = |(flag_ff & ~mask_ff);

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      INTERRUPT_OUT_N  <= 1'b1;
      MODULE_PRESENT_N <= 1'b0;
      LOW_POWER        <= 1'b1;
      LASER_EN         <= 1'b0;
      BUS_EN           <= 1'b0;
    end
    else
    begin
      INTERRUPT_OUT_N  <= ~pend;
      MODULE_PRESENT_N <= 1'b0;
      LOW_POWER        <= lp_s || state_ff == ST_PDOWN;
      // Laser only lit once running and not held off by the pin
      LASER_EN         <= !transmit_disable_in_s && state_ff == ST_RUN && !lp_s;
      BUS_EN           <= !sel_n_s && state_ff != ST_INIT;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [CNT_W-1:0] init_age_ff;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      init_age_ff <= '0;
    else if (state_ff != ST_INIT || rst_hold_ff)
      init_age_ff <= '0;
    else
      init_age_ff <= init_age_ff + CNT_W'(1);
  end

  sequence s_read_clears;
    rd_pulse ##1 !pend;
  endsequence

  sequence s_write_unmasks;
    wr_pulse ##1 pend;
  endsequence

  a_reset_filter: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    soft_rst |=> state_ff == ST_INIT && not_ready_ff)
    else $error("reset pulse did not restart init");

  a_init_bound: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    init_age_ff <= CNT_W'(INIT_CYCLES))
    else $error("init ran past its limit");

  a_ready_int: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $fell(not_ready_ff) && !mask_ff[FLAG_RDY] |-> ##[0:2] !INTERRUPT_OUT_N)
    else $error("ready event gave no interrupt");

  a_lp_entry: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $rose(lp_s) |=> LOW_POWER)
    else $error("low power request not honoured");

  a_flag_int: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    |(cond_rise & ~mask_ff[NFLAG-1:1]) && !soft_rst |-> ##[1:2] !INTERRUPT_OUT_N)
    else $error("flag condition gave no interrupt");

  a_read_release: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_read_clears |=> INTERRUPT_OUT_N)
    else $error("interrupt held after clearing read");

  a_mask_resume: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_write_unmasks |=> !INTERRUPT_OUT_N)
    else $error("interrupt not resumed after unmask");

  a_mask_inhibit: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    wr_pulse && !(|(flag_ff & ~wr_word_ff.mask)) && !(|flag_set) |-> ##2 INTERRUPT_OUT_N)
    else $error("mask did not inhibit interrupt");

  a_select_on: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !sel_n_s && state_ff == ST_RUN |=> BUS_EN)
    else $error("bus not answering when selected");

  a_select_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    sel_n_s |=> !BUS_EN)
    else $error("bus answering while deselected");

  a_pdown_entry: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    state_ff == ST_RUN && pdown_ff && !soft_rst |-> ##2 LOW_POWER)
    else $error("power-down bit not honoured");

  a_wake_exit: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    state_ff == ST_WAKE && cnt_done && !pdown_ff && !soft_rst |=> state_ff == ST_RUN)
    else $error("wake did not return to run");

  a_laser_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    transmit_disable_in_s |=> !LASER_EN)
    else $error("laser lit while disabled");

endmodule : mgmt_ctrl

// ==== dv/host_model.sv ====
// Host-side serial engine model: framed link clock and done strobes
`timescale 1ns/100ps

module host_model
  import mgmt_pkg::*;
(
  // Link towards the block
  output logic             SERIAL_CLK,
  output logic             RD_DONE,
  output logic [NFLAG-1:0] RD_SEL,
  output logic             WR_DONE,
  output wr_word_t         WR_WORD
);

  initial
  begin
    SERIAL_CLK = 1'b0;
    RD_DONE    = 1'b0;
    WR_DONE    = 1'b0;
    RD_SEL     = 4'hA;
    WR_WORD    = 5'h15;
  end

  // ==========================================================================
  // Link clock runs only while ticked, in frames or by the bench, 6 ns period
  // ==========================================================================
  task automatic tick(input int n);
    repeat (n)
    begin
      #3 SERIAL_CLK = 1'b1;
      #3 SERIAL_CLK = 1'b0;
    end
  endtask : tick

  // Strobe on the edge after the stop bit; data inverted once released
  task automatic frame(input logic rd, input logic [NFLAG-1:0] sel, input wr_word_t w);
    tick(4);
    RD_DONE = rd;
    WR_DONE = ~rd;
    RD_SEL  = sel;
    WR_WORD = w;
    tick(1);
    RD_DONE = 1'b0;
    WR_DONE = 1'b0;
    RD_SEL  = ~sel;
    WR_WORD = ~w;
    // Long tail keeps strobes well apart for the crossing
    tick(24);
  endtask : frame

endmodule : host_model

// ==== dv/module_mgmt_control_status_test.sv ====
// Self-checking bench for the management control and status block
`timescale 1ns/100ps

`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module module_mgmt_control_status_test;
  import mgmt_pkg::*;

  localparam int unsigned INIT_SIM = 50;
  localparam int unsigned WAKE_SIM = 20;

  logic             ref_clk;
  logic             rst_n;
  logic             mod_rst_n;
  logic             sel_n;
  logic             lp_req;
  logic             tx_dis;
  logic [NCOND-1:0] cond;
  logic             irq_n;
  logic             present_n;
  logic             low_power;
  logic             laser_en;
  logic             bus_en;
  logic             serial_clk;
  logic             rd_done;
  logic [NFLAG-1:0] rd_sel;
  logic             wr_done;
  wr_word_t         wr_word;
  status_t          status;
  int               bad_count;
  int               total_checks;
  int               seed;
  int               i;
  int               k;
  logic [NFLAG-1:0] m;

  mgmt_ctrl #(.INIT_CYCLES(INIT_SIM), .WAKE_CYCLES(WAKE_SIM)) i_dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .SERIAL_CLK(serial_clk),
    .MODULE_RESET_N(mod_rst_n), .MODULE_SELECT_N(sel_n), .LOW_POWER_REQUEST(lp_req),
    .TRANSMIT_DISABLE_IN(tx_dis), .FLAG_COND(cond), .INTERRUPT_OUT_N(irq_n),
    .MODULE_PRESENT_N(present_n), .LOW_POWER(low_power), .LASER_EN(laser_en),
    .BUS_EN(bus_en), .RD_DONE(rd_done), .RD_SEL(rd_sel), .WR_DONE(wr_done),
    .WR_WORD(wr_word), .STATUS(status)
  );

  host_model i_host (
    .SERIAL_CLK(serial_clk), .RD_DONE(rd_done), .RD_SEL(rd_sel),
    .WR_DONE(wr_done), .WR_WORD(wr_word)
  );

  always #10 ref_clk = ~ref_clk;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic exp_irq(input logic [NFLAG-1:0] f, input logic [NFLAG-1:0] mk);
    return ~|(f & ~mk);
  endfunction : exp_irq

  // Inputs set after a call move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // Bounded wait for the interrupt line to reach a level
  task automatic wait_irq(input logic lvl, input int bound);
    int n;
    n = 0;
    while (irq_n !== lvl && n < bound)
    begin
      cyc(1);
      n++;
    end
    total_checks++;
    if (n >= bound)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, irq_n, lvl);
      final_report();
    end
  endtask : wait_irq

  task automatic wr_ctl(input logic pd, input logic [NFLAG-1:0] mk);
    i_host.frame(1'b0, 4'h0, '{pdown: pd, mask: mk});
    cyc(6);
  endtask : wr_ctl

  task automatic rd_clr(input logic [NFLAG-1:0] s);
    i_host.frame(1'b1, s, WR_RST);
    cyc(6);
  endtask : rd_clr

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    seed = 32'h86002644;
    bad_count = 0;
    total_checks = 0;
    ref_clk = 1'b0;
    rst_n = 1'b0;
    mod_rst_n = 1'b1;
    sel_n = 1'b1;
    lp_req = 1'b0;
    tx_dis = 1'b0;
    cond = 3'h0;
    cyc(12);
    `CHK(irq_n, 1'b1)
    `CHK(present_n, 1'b0)
    rst_n = 1'b1;
    sel_n = 1'b0;
    cyc(20);
    `CHK(bus_en, 1'b0)
    wait_irq(1'b0, 60);
    `CHK(bus_en, 1'b1)
    `CHK(laser_en, 1'b1)
    i_host.tick(8);
    `CHK(status, 5'h02)
    rd_clr(4'h1);
    `CHK(irq_n, 1'b1)
    // Select and low-power pins
    sel_n = 1'b1;
    cyc(6);
    `CHK(bus_en, 1'b0)
    sel_n = 1'b0;
    cyc(6);
    `CHK(bus_en, 1'b1)
    lp_req = 1'b1;
    cyc(6);
    `CHK(low_power, 1'b1)
    lp_req = 1'b0;
    tx_dis = 1'b1;
    cyc(6);
    `CHK(low_power, 1'b0)
    `CHK(laser_en, 1'b0)
    tx_dis = 1'b0;
    cyc(6);
    `CHK(laser_en, 1'b1)
    // Random flag causes under random masks; first pass is an unmasked loss of signal
    for (i = 0; i < 8; i++)
    begin
      k = $unsigned($random(seed)) % NCOND;
      m = 4'($random(seed));
      if (i == 0)
      begin
        k = 0;
        m = 4'h0;
      end
      wr_ctl(1'b0, m);
      cond[k] = 1'b1;
      cyc(8);
      `CHK(irq_n, exp_irq(4'h1 << (k + 1), m))
      i_host.tick(8);
      `CHK(status.flags[k+1], 1'b1)
      wr_ctl(1'b0, ~m);
      `CHK(irq_n, exp_irq(4'h1 << (k + 1), ~m))
      wr_ctl(1'b0, m);
      `CHK(irq_n, exp_irq(4'h1 << (k + 1), m))
      cond[k] = 1'b0;
      rd_clr(4'hF);
      `CHK(irq_n, 1'b1)
    end
    // Two flags pending: one read leaves the line low
    wr_ctl(1'b0, 4'h0);
    cond = 3'h3;
    cyc(8);
    rd_clr(4'h2);
    `CHK(irq_n, 1'b0)
    rd_clr(4'h4);
    `CHK(irq_n, 1'b1)
    cond = 3'h0;
    // Power-down bit set and cleared
    wr_ctl(1'b1, 4'h0);
    `CHK(low_power, 1'b1)
    `CHK(bus_en, 1'b1)
    wr_ctl(1'b0, 4'h0);
    cyc(WAKE_SIM + 10);
    `CHK(low_power, 1'b0)
    `CHK(laser_en, 1'b1)
    // Reset pin: short pulse ignored, long pulse restarts init
    mod_rst_n = 1'b0;
    cyc(20);
    mod_rst_n = 1'b1;
    cyc(6);
    `CHK(bus_en, 1'b1)
    mod_rst_n = 1'b0;
    cyc(120);
    `CHK(bus_en, 1'b0)
    mod_rst_n = 1'b1;
    cyc(20);
    `CHK(bus_en, 1'b0)
    wait_irq(1'b0, 60);
    `CHK(bus_en, 1'b1)
    final_report();
  end

endmodule : module_mgmt_control_status_test
